// ==== loop_interlock_pkg.sv ====
// Behaviour
// RULE_01 - in pilot wire mode the send output rises whenever the distance function picks up.
// RULE_02 - the loop receive input is low-active, so a deenergized input means block.
// RULE_03 - while the loop reads open, no overreach zone trip is allowed.
// RULE_04 - after pickup, a forward fault in the overreach zone drops the send output so the loop closes.
// RULE_05 - the overreach trip is released only when both ends stop sending and the loop is energized again.
// RULE_06 - a fault not seen forward in the overreach zone keeps the send output up and the trip blocked.
// RULE_07 - first zone and other stages trip on their own timers, whatever the loop or scheme state.
// RULE_08 - an open loop lasting 10 s raises a pilot wire failure alarm and blocks the comparison internally.
// RULE_09 - the overreach zone trip waits a settable delay.
// RULE_10 - in reverse interlocking the overreach zone is blocked while a downstream pickup is received.
// RULE_11 - with no downstream pickup the overreach zone trips after its delay, set longer than downstream pickup.
// RULE_12 - reverse interlocking has a blocking mode (input high blocks) and a release mode (input low blocks).
// RULE_13 - after the interlock block clears, the overreach zone stays blocked for a settable transient time.
// RULE_14 - the transient prolongation applies only if the block lasted at least the settable waiting time.
// RULE_15 - all timers count a common millisecond tick and reset to idle with no send and no alarm.
// RULE_16 - the failure alarm clears and the comparison unblocks once the loop is energized again.
package loop_interlock_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PILOT_FAIL_S = 10;
  localparam int unsigned PILOT_FAIL_MS = PILOT_FAIL_S * 1000;
  localparam int unsigned MS_W = 16;

  // apb map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_OVR_DELAY = 12'h004;
  localparam logic [11:0] ADDR_FIRST_DELAY = 12'h008;
  localparam logic [11:0] ADDR_TB_TIME = 12'h00c;
  localparam logic [11:0] ADDR_WAIT_TIME = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;

  // ctrl fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_RELMODE_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [MS_W-1:0] OVR_DELAY_RESET = 16'h0032;
  localparam logic [MS_W-1:0] FIRST_DELAY_RESET = 16'h0000;
  localparam logic [MS_W-1:0] TB_TIME_RESET = 16'h0028;
  localparam logic [MS_W-1:0] WAIT_TIME_RESET = 16'h0028;

  // status fields
  localparam int unsigned ST_SEND_BIT = 0;
  localparam int unsigned ST_ALARM_BIT = 1;
  localparam int unsigned ST_BLOCK_BIT = 2;
  localparam int unsigned ST_LOOP_BIT = 3;
  localparam int unsigned ST_OVR_TRIP_BIT = 4;
  localparam int unsigned ST_FIRST_TRIP_BIT = 5;

  typedef enum logic {MODE_PILOT, MODE_REVERSE} scheme_t;

  typedef struct packed {
    logic pickup;
    logic fwd_overreach;
    logic first_zone_fault;
  } meas_t;

  typedef struct packed {
    logic [MS_W-1:0] overreach_zone_delay;
    logic [MS_W-1:0] first_zone_delay;
    logic [MS_W-1:0] transient_block_time;
    logic [MS_W-1:0] transient_wait_time;
    logic enable;
    scheme_t mode;
    logic release_mode;
  } cfg_t;

  typedef struct packed {
    logic send;
    logic alarm;
    logic ovr_block;
    logic loop_open;
    logic overreach_trip;
    logic first_zone_trip;
  } stat_t;

endpackage

// ==== ms_timer.sv ====
`timescale 1ns/1ps
// counts ticks while run is high, saturating; clears when run drops
module ms_timer #(
  parameter int unsigned WIDTH = 16
) (
  // clock
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // control
  input wire logic tick,
  input wire logic run,
  output logic [WIDTH-1:0] count
);

  // refused at elaboration, not at run time
  if (WIDTH < 2 || WIDTH > 32)
  begin
    $error("ms_timer width out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } st_t;

  st_t s_q;
  st_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!run)
    begin
      s_d.count = '0;
    end
    else if (tick && s_q.count != {WIDTH{1'b1}})
    begin
      s_d.count = s_q.count + WIDTH'(1); // RULE_15
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign count = s_q.count;

endmodule

// ==== loop_interlock.sv ====
`timescale 1ns/1ps
module loop_interlock #(
  parameter int unsigned TICK_CYCLES = loop_interlock_pkg::TICK_CYCLES,
  parameter int unsigned PILOT_FAIL_MS = loop_interlock_pkg::PILOT_FAIL_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protection measurements, same clock
  input wire loop_interlock_pkg::meas_t meas,
  // binary input from the loop or downstream contacts
  input wire logic teleprot_receive_ch1,
  // outputs
  output logic teleprot_send,
  output logic pilot_fail_alarm,
  output logic overreach_trip,
  output logic first_zone_trip
);

  localparam int unsigned TW = loop_interlock_pkg::MS_W;

  if (TICK_CYCLES < 1 || PILOT_FAIL_MS < 1 || PILOT_FAIL_MS >= (1 << TW))
  begin
    $error("loop_interlock timing parameters out of range");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a[11:2] == b[11:2]);
  endfunction

  typedef enum logic [1:0] {PW_IDLE, PW_SENDING, PW_CLOSED} pilot_st_t;

  typedef struct packed {
    logic [2:0] rx_sync;
    logic rx_level;
    logic [31:0] tick_cnt;
    logic tick;
    pilot_st_t pw;
    logic ri_prolong;
    logic alarm;
    loop_interlock_pkg::cfg_t cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    loop_interlock_pkg::stat_t st;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [TW-1:0] open_ms;
  logic [TW-1:0] ovr_ms;
  logic [TW-1:0] first_ms;
  logic [TW-1:0] blk_ms;
  logic [TW-1:0] tb_ms;
  logic loop_energized;
  logic ri_block_raw;
  logic ri_start;
  logic ovr_block;
  logic pilot_active;
  logic reverse_active;

  //////////////////////////////////////////////////////////////////////////////
  // timers

  // open loop duration for the failure alarm
  ms_timer #(.WIDTH(TW)) u_open (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(s_q.tick),
    .run(pilot_active && !loop_energized),
    .count(open_ms)
  );

  // overreach delay runs on pickup
  ms_timer #(.WIDTH(TW)) u_ovr (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(s_q.tick),
    .run(meas.pickup),
    .count(ovr_ms)
  );

  // first zone grading, independent of the scheme
  ms_timer #(.WIDTH(TW)) u_first (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(s_q.tick),
    .run(meas.first_zone_fault),
    .count(first_ms)
  ); // RULE_07

  // how long the interlock block has stood
  ms_timer #(.WIDTH(TW)) u_blk (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(s_q.tick),
    .run(reverse_active && ri_block_raw),
    .count(blk_ms)
  );

  // transient prolongation after the block drops
  ms_timer #(.WIDTH(TW)) u_tb (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(s_q.tick),
    .run(s_q.ri_prolong),
    .count(tb_ms)
  );

  //////////////////////////////////////////////////////////////////////////////
  // scheme logic

  always_comb
  begin
    loop_energized = s_q.rx_level; // RULE_02
    pilot_active = s_q.cfg.enable && s_q.cfg.mode == loop_interlock_pkg::MODE_PILOT;
    reverse_active = s_q.cfg.enable && s_q.cfg.mode == loop_interlock_pkg::MODE_REVERSE;
    // release mode: series nc contacts, low input means a downstream pickup
    ri_block_raw = s_q.cfg.release_mode ? !s_q.rx_level : s_q.rx_level; // RULE_12
    // block stood long enough: prolongation starts as it drops
    ri_start = reverse_active && !ri_block_raw && blk_ms != '0
        && blk_ms >= s_q.cfg.transient_wait_time && s_q.cfg.transient_block_time != '0; // RULE_14
    ovr_block = 1'b0;
    if (pilot_active)
    begin
      // open loop means far end or we still send; alarm blocks outright
      ovr_block = !loop_energized || s_q.alarm; // RULE_03 RULE_05 RULE_08
    end
    else if (reverse_active)
    begin
      // start term closes the one-cycle gap before prolong is registered
      ovr_block = ri_block_raw || s_q.ri_prolong || ri_start; // RULE_10 RULE_13
    end
  end

  always_comb
  begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // three-stage input sync; level moves only once stages 2 and 3 agree
    s_d.rx_sync = {s_q.rx_sync[1:0], teleprot_receive_ch1};
    if (s_q.rx_sync[2] == s_q.rx_sync[1])
    begin
      s_d.rx_level = s_q.rx_sync[2];
    end
    // common millisecond tick
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= TICK_CYCLES - 1)
    begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1; // RULE_15
    end
    else
    begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
    end

    // pilot wire send sequence
    case (s_q.pw)
      PW_IDLE:
      begin
        if (pilot_active && meas.pickup)
        begin
          s_d.pw = PW_SENDING; // RULE_01
        end
      end
      PW_SENDING:
      begin
        if (!pilot_active || !meas.pickup)
        begin
          s_d.pw = PW_IDLE;
        end
        else if (meas.fwd_overreach)
        begin
          s_d.pw = PW_CLOSED; // RULE_04
        end
        // reverse or non-forward fault holds the contact open
      end
      PW_CLOSED:
      begin
        if (!pilot_active || !meas.pickup)
        begin
          s_d.pw = PW_IDLE;
        end
      end
      default:
      begin
        s_d.pw = PW_IDLE;
      end
    endcase
    s_d.st.send = (s_d.pw == PW_SENDING); // RULE_06

    // pilot failure alarm, self-clearing when the loop is healthy again
    if (!pilot_active || loop_energized)
    begin
      s_d.alarm = 1'b0; // RULE_16
    end
    else if (open_ms >= TW'(PILOT_FAIL_MS))
    begin
      s_d.alarm = 1'b1; // RULE_08
    end

    // transient prolongation, only after a long enough block
    if (!reverse_active)
    begin
      s_d.ri_prolong = 1'b0;
    end
    else if (ri_block_raw)
    begin
      s_d.ri_prolong = 1'b0;
    end
    else if (s_q.ri_prolong && tb_ms >= s_q.cfg.transient_block_time)
    begin
      s_d.ri_prolong = 1'b0; // RULE_13
    end
    if (ri_start)
    begin
      s_d.ri_prolong = 1'b1; // RULE_14
    end

    // trips
    s_d.st.overreach_trip = s_q.cfg.enable && meas.pickup && meas.fwd_overreach && !ovr_block
        && ovr_ms >= s_q.cfg.overreach_zone_delay; // RULE_09 RULE_11
    s_d.st.first_zone_trip = meas.first_zone_fault && first_ms >= s_q.cfg.first_zone_delay; // RULE_07
    s_d.st.alarm = s_d.alarm;
    s_d.st.ovr_block = ovr_block;
    s_d.st.loop_open = !loop_energized;

    // apb: access phase answered in one cycle
    if (psel && penable && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (hit(paddr, loop_interlock_pkg::ADDR_CTRL))
      begin
        if (pwrite)
        begin
          s_d.cfg.enable = pwdata[loop_interlock_pkg::CTRL_EN_BIT];
          s_d.cfg.mode = loop_interlock_pkg::scheme_t'(pwdata[loop_interlock_pkg::CTRL_MODE_BIT]);
          s_d.cfg.release_mode = pwdata[loop_interlock_pkg::CTRL_RELMODE_BIT];
        end
        s_d.prdata[loop_interlock_pkg::CTRL_EN_BIT] = s_q.cfg.enable;
        s_d.prdata[loop_interlock_pkg::CTRL_MODE_BIT] = s_q.cfg.mode;
        s_d.prdata[loop_interlock_pkg::CTRL_RELMODE_BIT] = s_q.cfg.release_mode;
      end
      else if (hit(paddr, loop_interlock_pkg::ADDR_OVR_DELAY))
      begin
        if (pwrite)
        begin
          s_d.cfg.overreach_zone_delay = pwdata[TW-1:0];
        end
        s_d.prdata[TW-1:0] = s_q.cfg.overreach_zone_delay;
      end
      else if (hit(paddr, loop_interlock_pkg::ADDR_FIRST_DELAY))
      begin
        if (pwrite)
        begin
          s_d.cfg.first_zone_delay = pwdata[TW-1:0];
        end
        s_d.prdata[TW-1:0] = s_q.cfg.first_zone_delay;
      end
      else if (hit(paddr, loop_interlock_pkg::ADDR_TB_TIME))
      begin
        if (pwrite)
        begin
          s_d.cfg.transient_block_time = pwdata[TW-1:0];
        end
        s_d.prdata[TW-1:0] = s_q.cfg.transient_block_time;
      end
      else if (hit(paddr, loop_interlock_pkg::ADDR_WAIT_TIME))
      begin
        if (pwrite)
        begin
          s_d.cfg.transient_wait_time = pwdata[TW-1:0];
        end
        s_d.prdata[TW-1:0] = s_q.cfg.transient_wait_time;
      end
      else if (hit(paddr, loop_interlock_pkg::ADDR_STATUS))
      begin
        // read only; writes are ignored without error
        s_d.prdata[loop_interlock_pkg::ST_SEND_BIT] = s_q.st.send;
        s_d.prdata[loop_interlock_pkg::ST_ALARM_BIT] = s_q.st.alarm;
        s_d.prdata[loop_interlock_pkg::ST_BLOCK_BIT] = s_q.st.ovr_block;
        s_d.prdata[loop_interlock_pkg::ST_LOOP_BIT] = s_q.st.loop_open;
        s_d.prdata[loop_interlock_pkg::ST_OVR_TRIP_BIT] = s_q.st.overreach_trip;
        s_d.prdata[loop_interlock_pkg::ST_FIRST_TRIP_BIT] = s_q.st.first_zone_trip;
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // idle: sync chain reads energized loop so no block at start
      s_q <= '0; // RULE_15
      s_q.rx_sync <= 3'h7;
      s_q.rx_level <= 1'b1;
      s_q.pw <= PW_IDLE;
      s_q.cfg.overreach_zone_delay <= loop_interlock_pkg::OVR_DELAY_RESET;
      s_q.cfg.first_zone_delay <= loop_interlock_pkg::FIRST_DELAY_RESET;
      s_q.cfg.transient_block_time <= loop_interlock_pkg::TB_TIME_RESET;
      s_q.cfg.transient_wait_time <= loop_interlock_pkg::WAIT_TIME_RESET;
      s_q.cfg.mode <= loop_interlock_pkg::MODE_PILOT;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign teleprot_send = s_q.st.send;
  assign pilot_fail_alarm = s_q.st.alarm;
  assign overreach_trip = s_q.st.overreach_trip;
  assign first_zone_trip = s_q.st.first_zone_trip;

endmodule

// ==== loop_interlock_props.sv ====
`timescale 1ns/1ps
module loop_interlock_props #(
  parameter int unsigned TICK_CYCLES = loop_interlock_pkg::TICK_CYCLES,
  parameter int unsigned PILOT_FAIL_MS = loop_interlock_pkg::PILOT_FAIL_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // scheme
  input wire loop_interlock_pkg::meas_t meas,
  input wire logic teleprot_receive_ch1,
  input wire logic teleprot_send,
  input wire logic pilot_fail_alarm,
  input wire logic overreach_trip,
  input wire logic first_zone_trip
);
  logic [2:0] ctrl_q;
  logic [31:0] low_q;
  // mode shadow taken at the edge the slave applies the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= 3'h0;
      low_q <= 32'h0000_0000;
    end
    else
    begin
      if (psel && penable && pwrite && !pready && clk_en && paddr == loop_interlock_pkg::ADDR_CTRL)
        ctrl_q <= pwdata[2:0];
      low_q <= teleprot_receive_ch1 ? 32'h0000_0000 : low_q + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////
  AST_RESET_IDLE: assert property ($rose(presetn) |-> !teleprot_send && !pilot_fail_alarm && !overreach_trip)
    else $error("outputs busy after reset");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_WAIT: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("no answer after access");
  AST_SEND_PICKUP: assert property (ctrl_q == 3'h1 && !pilot_fail_alarm && $rose(meas.pickup) && !meas.fwd_overreach |=> teleprot_send)
    else $error("send not raised on pickup");
  AST_SEND_DROP: assert property (ctrl_q == 3'h1 && meas.pickup && meas.fwd_overreach |=> !teleprot_send)
    else $error("send kept on forward fault");
  AST_LOOP_BLOCK: assert property ((!teleprot_receive_ch1 && (!ctrl_q[1] || ctrl_q[2])) [*7] |-> !overreach_trip)
    else $error("trip while input low");
  AST_REV_BLOCK: assert property ((teleprot_receive_ch1 && ctrl_q[1] && !ctrl_q[2]) [*7] |-> !overreach_trip)
    else $error("trip while downstream picked up");
  AST_FIRST_CAUSE: assert property (!meas.first_zone_fault [*3] |-> !first_zone_trip)
    else $error("first zone trip without fault");
  AST_ALARM_DELAY: assert property ($rose(pilot_fail_alarm) |-> low_q >= (PILOT_FAIL_MS - 1) * TICK_CYCLES)
    else $error("alarm too early");
  AST_ALARM_CLEAR: assert property (teleprot_receive_ch1 [*7] |-> !pilot_fail_alarm)
    else $error("alarm kept with loop energized");
  cover property ($rose(overreach_trip));
  cover property ($rose(pilot_fail_alarm));
  cover property (pready && pslverr && prdata == 32'h0000_0000);
endmodule

bind loop_interlock loop_interlock_props #(.TICK_CYCLES(TICK_CYCLES), .PILOT_FAIL_MS(PILOT_FAIL_MS))
  loop_interlock_props_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas(meas), .teleprot_receive_ch1(teleprot_receive_ch1), .teleprot_send(teleprot_send),
  .pilot_fail_alarm(pilot_fail_alarm), .overreach_trip(overreach_trip), .first_zone_trip(first_zone_trip));

// ==== remote_relay_model.sv ====
`timescale 1ns/1ps
// far end: remote loop contact or downstream contacts
module remote_relay_model #(
  parameter int LAG = 3
) (
  // clock
  input wire logic pclk,
  // local contact
  input wire logic local_send,
  // scenario control
  input wire logic pickup,
  input wire logic fwd,
  input wire logic cut,
  input wire logic rev,
  input wire logic rel,
  input wire logic down,
  // receive level
  output logic rx
);
  logic [LAG-1:0] lag_q;
  initial
  begin
    lag_q = '0;
    rx = 1'b1;
  end
  // remote relay is slower than ours, so its contact lags
  always @(posedge pclk)
  begin
    lag_q <= {lag_q[LAG-2:0], pickup && !fwd};
    if (rev)
      rx <= rel ? !down : down;
    else
      rx <= !cut && !local_send && !lag_q[LAG-1];
  end
endmodule

// ==== loop_interlock_bench.sv ====
`timescale 1ns/1ps
module loop_interlock_bench;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  loop_interlock_pkg::meas_t meas;
  logic rx, send, alarm, ovr_trip, fz_trip, r_pick, r_fwd, cut, rev, rel, down;
  int failures, total_checks, cyc;
  loop_interlock #(.TICK_CYCLES(4), .PILOT_FAIL_MS(20)) loop_interlock_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas), .teleprot_receive_ch1(rx),
    .teleprot_send(send), .pilot_fail_alarm(alarm), .overreach_trip(ovr_trip), .first_zone_trip(fz_trip));
  remote_relay_model remote_relay_model_inst (.pclk(pclk), .local_send(send), .pickup(r_pick), .fwd(r_fwd),
    .cut(cut), .rev(rev), .rel(rel), .down(down), .rx(rx));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // entered just after an edge; request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the bench timeout ends a hung wait
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd, e);
  endtask
  task automatic t_regs;
    logic [11:0] adr [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
    logic [31:0] exp [6] = '{32'h0000_0000, 32'h0000_0032, 32'h0000_0000, 32'h0000_0028, 32'h0000_0028, 32'h0000_0000};
    for (int i = 0; i < 6; i++)
      rchk("reset value", adr[i], exp[i]);
    apb(1'b1, 12'h014, 32'hffff_ffff);
    rchk("status read only", 12'h014, 32'h0000_0000);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 0);
  endtask
  task automatic t_pilot(input logic rpk, input logic lfwd, input logic rfwd, input logic exp);
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0005);
    meas.pickup <= 1'b1;
    r_pick <= rpk;
    cycles(3);
    chk("send on pickup", send, 1);
    meas.fwd_overreach <= lfwd;
    r_fwd <= rfwd;
    cycles(2);
    chk("send after direction", send, !lfwd);
    cycles(9);
    chk("trip before delay", ovr_trip, 0);
    meas.first_zone_fault <= 1'b1;
    cycles(26);
    chk("overreach trip", ovr_trip, exp);
    chk("first zone trip", fz_trip, 1);
    meas <= '0;
    r_pick <= 1'b0;
    r_fwd <= 1'b0;
    cycles(20);
  endtask
  task automatic t_alarm;
    cut <= 1'b1;
    cycles(60);
    chk("alarm early", alarm, 0);
    cycles(40);
    chk("alarm", alarm, 1);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("status alarm", rd[1], 1);
    cut <= 1'b0;
    cycles(10);
    chk("alarm cleared", alarm, 0);
    cut <= 1'b1;
    cycles(100);
    presetn <= 1'b0;
    cycles(4);
    presetn <= 1'b1;
    cut <= 1'b0;
    cycles(1);
    chk("alarm after reset", alarm, 0);
    chk("send after reset", send, 0);
  endtask
  // overreach delay 3 ms is set longer than the downstream pickup lead of 6 cycles
  task automatic t_rev(input logic rl, input int hold, input logic pro);
    rev <= 1'b1;
    rel <= rl;
    down <= 1'b0;
    apb(1'b1, 12'h000, rl ? 32'h0000_0007 : 32'h0000_0003);
    apb(1'b1, 12'h004, 32'h0000_0003);
    apb(1'b1, 12'h00c, 32'h0000_000a);
    apb(1'b1, 12'h010, 32'h0000_0004);
    down <= 1'b1;
    cycles(6);
    // fault in the overreach zone, forward
    meas.pickup <= 1'b1;
    meas.fwd_overreach <= 1'b1;
    cycles(hold);
    chk("blocked trip", ovr_trip, 0);
    down <= 1'b0;
    cycles(30);
    chk("transient block", ovr_trip, !pro);
    cycles(40);
    chk("released trip", ovr_trip, 1);
    meas <= '0;
    cycles(20);
  endtask
  //////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    failures = 0;
    total_checks = 0;
    cyc = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    meas = '0;
    {r_pick, r_fwd, cut, rev, rel, down} = '0;
    cycles(4);
    presetn <= 1'b1;
    cycles(1);
    t_regs;
    t_pilot(1'b1, 1'b1, 1'b1, 1'b1);
    t_pilot(1'b1, 1'b1, 1'b0, 1'b0);
    t_pilot(1'b1, 1'b0, 1'b1, 1'b0);
    t_pilot(1'b0, 1'b1, 1'b0, 1'b1);
    t_alarm;
    t_rev(1'b0, 60, 1'b1);
    t_rev(1'b1, 60, 1'b1);
    t_rev(1'b0, 2, 1'b0);
    print_verdict;
  end
endmodule
